// >>> pkg/flash_host_pkg.sv
// Purpose: Shared constants and types for the lock-bit flash host controller.
// Assumes: Clock of 200 MHz; byte-wide flash with an asynchronous SRAM-like bus.
// Notes: Pin timing values are plain defaults and may be tuned per board.
package flash_host_pkg;

	// ==========================================================
	// Clock and timing
	localparam int CLK_MHZ = 200;
	localparam int TMR_W = 8;
	localparam int SYNC_STAGES = 2;
	localparam int WE_LOW_NS = 60;
	localparam int WE_HIGH_NS = 40;
	localparam int RD_ACCESS_NS = 150;
	localparam int RD_HIGH_NS = 40;
	// Least times round up to whole cycles, never below one.
	localparam int WE_LOW_RAW = (WE_LOW_NS * CLK_MHZ + 999) / 1000;
	localparam int WE_HIGH_RAW = (WE_HIGH_NS * CLK_MHZ + 999) / 1000;
	localparam int RD_ACCESS_RAW = (RD_ACCESS_NS * CLK_MHZ + 999) / 1000;
	localparam int RD_HIGH_RAW = (RD_HIGH_NS * CLK_MHZ + 999) / 1000;
	localparam logic [TMR_W-1:0] WE_LOW_CYC = TMR_W'((WE_LOW_RAW < 1) ? 1 : WE_LOW_RAW);
	localparam logic [TMR_W-1:0] WE_HIGH_CYC = TMR_W'((WE_HIGH_RAW < 1) ? 1 : WE_HIGH_RAW);
	// Read window also covers the pin register lag and the data synchroniser.
	localparam logic [TMR_W-1:0] RD_ACCESS_CYC = TMR_W'(RD_ACCESS_RAW + SYNC_STAGES + 1);
	localparam logic [TMR_W-1:0] RD_HIGH_CYC = TMR_W'((RD_HIGH_RAW < 1) ? 1 : RD_HIGH_RAW);

	// ==========================================================
	// Flash command codes
	localparam logic [7:0] CODE_LOCK_SETUP = 8'h60;
	localparam logic [7:0] CODE_BLOCK_CONFIRM = 8'h01;
	localparam logic [7:0] CODE_MASTER_CONFIRM = 8'hF1;
	localparam logic [7:0] CODE_CLEAR_CONFIRM = 8'hD0;
	localparam logic [7:0] CODE_READ_ARRAY = 8'hFF;
	localparam logic [7:0] CODE_CLEAR_STATUS_DEF = 8'h50;

	// ==========================================================
	// Flash status byte bit positions
	localparam int SB_READY = 7;
	localparam int SB_ERASE_CLEAR = 5;
	localparam int SB_PROGRAM_SET = 4;
	localparam int SB_SUPPLY = 3;
	localparam int SB_PROTECT = 1;

	// ==========================================================
	// Host registers on APB
	localparam int APB_ADDR_W = 12;
	localparam logic [APB_ADDR_W-1:0] REG_CTRL = 12'h000;
	localparam logic [APB_ADDR_W-1:0] REG_ADDR = 12'h004;
	localparam logic [APB_ADDR_W-1:0] REG_STATUS = 12'h008;
	localparam logic [APB_ADDR_W-1:0] REG_DATA = 12'h00C;
	localparam int CTRL_OP_LSB = 0;
	localparam int CTRL_OP_W = 3;
	localparam int CTRL_ELEV_BIT = 4;
	localparam int CTRL_PD_BIT = 5;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_RYBY_BIT = 1;
	localparam int STAT_REFUSED_BIT = 2;
	localparam int STAT_PENDING_BIT = 3;
	localparam int STAT_ERR_LSB = 8;
	localparam int STAT_BYTE_LSB = 16;

	// Sticky error vector positions.
	localparam int ERR_W = 5;
	localparam int E_SUPPLY = 0;
	localparam int E_PROTECT = 1;
	localparam int E_SEQUENCE = 2;
	localparam int E_ERASE_CLEAR = 3;
	localparam int E_SET = 4;

	typedef enum logic [2:0] {
		OP_NONE = 3'h0,
		OP_SET_BLOCK = 3'h1,
		OP_SET_MASTER = 3'h2,
		OP_CLEAR_LOCKS = 3'h3,
		OP_READ_ARRAY = 3'h4,
		OP_CLEAR_STATUS = 3'h5,
		OP_READ_STATUS = 3'h6
	} op_e;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_WR_SETUP = 3'h1,
		ST_WR_PULSE = 3'h2,
		ST_WR_HOLD = 3'h3,
		ST_RD_ACCESS = 3'h4,
		ST_RD_HOLD = 3'h5,
		ST_CHECK = 3'h6
	} seq_state_e;

	// True for the two-cycle lock-bit operations.
	function automatic logic is_lock_op(input logic [2:0] op);
		is_lock_op = (op == OP_SET_BLOCK) || (op == OP_SET_MASTER) || (op == OP_CLEAR_LOCKS);
	endfunction

endpackage

// >>> verilog/bit_sync.sv
// Purpose: Two-stage synchroniser for pin inputs.
// Assumes: Each bit is an independent level or is sampled only when stable.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/1ps
module bit_sync #(
	parameter int WIDTH = 1
) (
	input wire logic i_ref_clk,
	input wire logic i_rstn,
	input wire logic [WIDTH-1:0] i_async,
	output logic [WIDTH-1:0] o_sync
);

	logic [WIDTH-1:0] meta_r;

	// ==========================================================
	// Two flip-flops in series, cleared by reset.
	always_ff @(posedge i_ref_clk)
	begin
		if (!i_rstn)
		begin
			meta_r <= '0;
			o_sync <= '0;
		end
		else
		begin
			meta_r <= i_async;
			o_sync <= meta_r;
		end
	end

endmodule

// >>> verilog/cycle_timer.sv
// Purpose: Counts the cycles that a timed sequencer state lasts.
// Assumes: The limit is at least one while the timer runs.
// Notes: The count restarts at zero after each completion.
`timescale 1ns/1ps
module cycle_timer #(
	parameter int WIDTH = 8
) (
	input wire logic i_ref_clk,
	input wire logic i_rstn,
	input wire logic i_run,
	input wire logic [WIDTH-1:0] i_limit,
	output logic o_done
);

	logic [WIDTH-1:0] cnt_r;

	// Done in the last cycle of the window.
	assign o_done = i_run && (cnt_r == (i_limit - WIDTH'(1)));

	// ==========================================================
	// Counter clears when idle or on completion so back-to-back states start fresh.
	always_ff @(posedge i_ref_clk)
	begin
		if (!i_rstn)
			cnt_r <= '0;
		else if (!i_run || o_done)
			cnt_r <= '0;
		else
			cnt_r <= cnt_r + WIDTH'(1);
	end

endmodule

// >>> verilog/flash_lock_host.sv
// Purpose: Host controller that runs lock-bit sequences on a byte-wide flash.
// Assumes: Software reaches the controller over APB; the flash pins are asynchronous.
// Notes: Pin outputs are registered and lag the sequencer state by one cycle.
// Contract
// - Set lock: write 60H then 01H/F1H.
// - Clear all locks: write 60H then D0H.
// - Write FFH to return to read array.
// - Clear status before any retry after error.
// - Check status per operation; errors accumulate.
// - Reset pin follows power good and reset.
//
// The placing of the registers and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module flash_lock_host #(
	parameter int ADDR_W = 20,
	parameter logic [7:0] CLEAR_STATUS_CODE = flash_host_pkg::CODE_CLEAR_STATUS_DEF
) (
	input wire logic i_ref_clk,
	input wire logic i_rstn,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [flash_host_pkg::APB_ADDR_W-1:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	output logic [ADDR_W-1:0] o_flash_addr,
	output logic [7:0] o_flash_dq_out,
	output logic o_flash_dq_oe,
	input wire logic [7:0] i_flash_dq_in,
	output logic o_flash_ce_n,
	output logic o_flash_oe_n,
	output logic o_flash_we_n,
	output logic o_reset_powerdown_n,
	output logic o_reset_powerdown_elevate,
	input wire logic i_ready_busy_output,
	input wire logic i_system_power_good
);
	import flash_host_pkg::*;

	logic [9:0] sync_w;
	logic [7:0] dq_sync;
	logic ryby_sync;
	logic pg_sync;
	logic apb_setup;
	logic apb_access;
	logic apb_wr;
	logic mapped;
	logic [2:0] req_op;
	logic start_req;
	logic accept;
	logic [31:0] rd_mux;
	seq_state_e state_r;
	logic [2:0] op_r;
	logic second_r;
	logic [ADDR_W-1:0] addr_r;
	logic elevated_r;
	logic powerdown_r;
	logic refused_r;
	logic [ERR_W-1:0] err_r;
	logic [ERR_W-1:0] new_err;
	logic err_pending;
	logic [7:0] status_byte_r;
	logic [7:0] data_r;
	logic [7:0] cur_code;
	logic tmr_run;
	logic tmr_done;
	logic [TMR_W-1:0] tmr_limit;
	logic clear_done;

	// ==========================================================
	// Pin input synchronisation
	bit_sync #(
		.WIDTH(10)
	) u_sync (
		.i_ref_clk(i_ref_clk),
		.i_rstn(i_rstn),
		.i_async({i_system_power_good, i_ready_busy_output, i_flash_dq_in}),
		.o_sync(sync_w)
	);

	// Split the synchronised bundle.
	assign dq_sync = sync_w[7:0];
	assign ryby_sync = sync_w[8];
	assign pg_sync = sync_w[9];

	// ==========================================================
	// APB slave decode
	// Zero-wait slave; unmapped addresses answer with an error.
	assign apb_setup = i_psel && !i_penable;
	assign apb_access = i_psel && i_penable;
	assign apb_wr = apb_access && i_pwrite;
	assign mapped = (i_paddr == REG_CTRL) || (i_paddr == REG_ADDR) ||
		(i_paddr == REG_STATUS) || (i_paddr == REG_DATA);
	assign o_pready = 1'b1;
	assign o_pslverr = apb_access && !mapped;

	// Command start and its acceptance.
	assign req_op = i_pwdata[CTRL_OP_LSB +: CTRL_OP_W];
	assign start_req = apb_wr && (i_paddr == REG_CTRL) && (req_op != OP_NONE);
	assign err_pending = |err_r;
	assign accept = start_req && (state_r == ST_IDLE) &&
		!(err_pending && is_lock_op(req_op));

	// Read data multiplexer for the register file.
	always_comb
	begin
		rd_mux = 32'h0000_0000;
		case (i_paddr)
			REG_CTRL:
			begin
				rd_mux[CTRL_OP_LSB +: CTRL_OP_W] = op_r;
				rd_mux[CTRL_ELEV_BIT] = elevated_r;
				rd_mux[CTRL_PD_BIT] = powerdown_r;
			end
			REG_ADDR:
				rd_mux[ADDR_W-1:0] = addr_r;
			REG_STATUS:
			begin
				rd_mux[STAT_BUSY_BIT] = (state_r != ST_IDLE);
				rd_mux[STAT_RYBY_BIT] = ryby_sync;
				rd_mux[STAT_REFUSED_BIT] = refused_r;
				rd_mux[STAT_PENDING_BIT] = err_pending;
				rd_mux[STAT_ERR_LSB +: ERR_W] = err_r;
				rd_mux[STAT_BYTE_LSB +: 8] = status_byte_r;
			end
			REG_DATA:
				rd_mux[7:0] = data_r;
			default:
				rd_mux = 32'h0000_0000;
		endcase
	end

	// Read data is registered in the setup cycle and stands through the access.
	always_ff @(posedge i_ref_clk)
	begin
		if (!i_rstn)
			o_prdata <= 32'h0000_0000;
		else if (apb_setup && !i_pwrite)
			o_prdata <= rd_mux;
	end

	// ==========================================================
	// Software-written control bits
	always_ff @(posedge i_ref_clk)
	begin
		if (!i_rstn)
		begin
			elevated_r <= 1'b0;
			powerdown_r <= 1'b0;
			addr_r <= '0;
		end
		else
		begin
			if (apb_wr && (i_paddr == REG_CTRL))
			begin
				elevated_r <= i_pwdata[CTRL_ELEV_BIT];
				powerdown_r <= i_pwdata[CTRL_PD_BIT];
			end
			// The address is frozen while a sequence runs.
			if (apb_wr && (i_paddr == REG_ADDR) && (state_r == ST_IDLE))
				addr_r <= i_pwdata[ADDR_W-1:0];
		end
	end

	// Refused flag: set on a rejected start, cleared by the next accepted one.
	always_ff @(posedge i_ref_clk)
	begin
		if (!i_rstn)
			refused_r <= 1'b0;
		else if (start_req && !accept)
			refused_r <= 1'b1;
		else if (accept)
			refused_r <= 1'b0;
	end

	// ==========================================================
	// Command byte selection
	always_comb
	begin
		cur_code = CODE_READ_ARRAY;
		if (is_lock_op(op_r) && !second_r)
			cur_code = CODE_LOCK_SETUP;
		else if (op_r == OP_SET_BLOCK)
			cur_code = CODE_BLOCK_CONFIRM;
		else if (op_r == OP_SET_MASTER)
			cur_code = CODE_MASTER_CONFIRM;
		else if (op_r == OP_CLEAR_LOCKS)
			cur_code = CODE_CLEAR_CONFIRM;
		else if (op_r == OP_CLEAR_STATUS)
			cur_code = CLEAR_STATUS_CODE;
		else
			cur_code = CODE_READ_ARRAY;
	end

	// Timed states and their lengths.
	always_comb
	begin
		tmr_run = 1'b1;
		case (state_r)
			ST_WR_PULSE:
				tmr_limit = WE_LOW_CYC;
			ST_WR_HOLD:
				tmr_limit = WE_HIGH_CYC;
			ST_RD_ACCESS:
				tmr_limit = RD_ACCESS_CYC;
			ST_RD_HOLD:
				tmr_limit = RD_HIGH_CYC;
			default:
			begin
				tmr_run = 1'b0;
				tmr_limit = WE_LOW_CYC;
			end
		endcase
	end

	cycle_timer #(
		.WIDTH(TMR_W)
	) u_timer (
		.i_ref_clk(i_ref_clk),
		.i_rstn(i_rstn),
		.i_run(tmr_run),
		.i_limit(tmr_limit),
		.o_done(tmr_done)
	);

	// ==========================================================
	// Sequencer: two writes for lock ops, then status polling and the check
	always_ff @(posedge i_ref_clk)
	begin
		if (!i_rstn)
		begin
			state_r <= ST_IDLE;
			op_r <= OP_NONE;
			second_r <= 1'b0;
		end
		else
		begin
			case (state_r)
				ST_IDLE:
					if (accept)
					begin
						op_r <= req_op;
						second_r <= 1'b0;
						// Status reads need no command after a lock setup.
						state_r <= (req_op == OP_READ_STATUS) ? ST_RD_ACCESS : ST_WR_SETUP;
					end
				ST_WR_SETUP:
					state_r <= ST_WR_PULSE;
				ST_WR_PULSE:
					if (tmr_done)
						state_r <= ST_WR_HOLD;
				ST_WR_HOLD:
					if (tmr_done)
					begin
						if (is_lock_op(op_r) && !second_r)
						begin
							second_r <= 1'b1;
							state_r <= ST_WR_SETUP;
						end
						else if (is_lock_op(op_r))
							state_r <= ST_RD_ACCESS;
						else
							state_r <= ST_IDLE;
					end
				ST_RD_ACCESS:
					if (tmr_done)
						state_r <= ST_RD_HOLD;
				ST_RD_HOLD:
					if (tmr_done)
					begin
						if (!is_lock_op(op_r))
							state_r <= ST_IDLE;
						else if (status_byte_r[SB_READY])
							state_r <= ST_CHECK;
						else
							state_r <= ST_RD_ACCESS;
					end
				ST_CHECK:
					state_r <= ST_IDLE;
				default:
					state_r <= ST_IDLE;
			endcase
		end
	end

	// Read capture at the end of the access window.
	always_ff @(posedge i_ref_clk)
	begin
		if (!i_rstn)
		begin
			status_byte_r <= 8'h00;
			data_r <= 8'h00;
		end
		else if ((state_r == ST_RD_ACCESS) && tmr_done)
		begin
			data_r <= dq_sync;
			if (is_lock_op(op_r) || (op_r == OP_READ_STATUS))
				status_byte_r <= dq_sync;
		end
	end

	// ==========================================================
	// Full status check, sticky error accumulation
	always_comb
	begin
		new_err = '0;
		new_err[E_SUPPLY] = status_byte_r[SB_SUPPLY];
		new_err[E_PROTECT] = status_byte_r[SB_PROTECT];
		new_err[E_SEQUENCE] = status_byte_r[SB_ERASE_CLEAR] && status_byte_r[SB_PROGRAM_SET];
		new_err[E_ERASE_CLEAR] = status_byte_r[SB_ERASE_CLEAR] &&
			!status_byte_r[SB_PROGRAM_SET] && (op_r == OP_CLEAR_LOCKS);
		new_err[E_SET] = status_byte_r[SB_PROGRAM_SET] &&
			!status_byte_r[SB_ERASE_CLEAR] && (op_r != OP_CLEAR_LOCKS);
	end

	assign clear_done = (state_r == ST_WR_HOLD) && tmr_done && (op_r == OP_CLEAR_STATUS);

	// Errors only grow during checks; the clear runs in a different state.
	always_ff @(posedge i_ref_clk)
	begin
		if (!i_rstn)
			err_r <= '0;
		else if (state_r == ST_CHECK)
			err_r <= err_r | new_err;
		else if (clear_done)
			err_r <= '0;
	end

	// ==========================================================
	// Flash bus pins, one cycle behind the sequencer state
	always_ff @(posedge i_ref_clk)
	begin
		if (!i_rstn)
		begin
			o_flash_addr <= '0;
			o_flash_dq_out <= 8'h00;
			o_flash_dq_oe <= 1'b0;
			o_flash_ce_n <= 1'b1;
			o_flash_oe_n <= 1'b1;
			o_flash_we_n <= 1'b1;
		end
		else
		begin
			o_flash_addr <= addr_r;
			o_flash_dq_out <= cur_code;
			o_flash_dq_oe <= (state_r == ST_WR_SETUP) || (state_r == ST_WR_PULSE) ||
				(state_r == ST_WR_HOLD);
			o_flash_ce_n <= !((state_r == ST_WR_SETUP) || (state_r == ST_WR_PULSE) ||
				(state_r == ST_RD_ACCESS));
			o_flash_oe_n <= (state_r != ST_RD_ACCESS);
			o_flash_we_n <= (state_r != ST_WR_PULSE);
		end
	end

	// Reset pin is low during controller reset and whenever power is not good.
	always_ff @(posedge i_ref_clk)
	begin
		if (!i_rstn)
		begin
			o_reset_powerdown_n <= 1'b0;
			o_reset_powerdown_elevate <= 1'b0;
		end
		else
		begin
			o_reset_powerdown_n <= pg_sync && !powerdown_r;
			o_reset_powerdown_elevate <= pg_sync && !powerdown_r && elevated_r;
		end
	end

	// ==========================================================
	// Checks on the host-side sequences
	chk_setup_code: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
		$fell(o_flash_we_n) && !second_r && is_lock_op(op_r) |-> o_flash_dq_out == CODE_LOCK_SETUP)
		else $error("Lock setup write did not carry the setup code");
	chk_lock_confirm: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
		$fell(o_flash_we_n) && second_r && (op_r == OP_SET_MASTER || op_r == OP_SET_BLOCK)
		|-> o_flash_dq_out == ((op_r == OP_SET_MASTER) ? CODE_MASTER_CONFIRM : CODE_BLOCK_CONFIRM))
		else $error("Set lock confirm code is wrong");
	chk_clear_confirm: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
		$fell(o_flash_we_n) && second_r && (op_r == OP_CLEAR_LOCKS) |->
		o_flash_dq_out == CODE_CLEAR_CONFIRM ##[1:300] $rose(o_flash_we_n))
		else $error("Clear locks confirm code or pulse is wrong");
	chk_read_array: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
		$fell(o_flash_we_n) && (op_r == OP_READ_ARRAY) |-> o_flash_dq_out == CODE_READ_ARRAY)
		else $error("Read array write did not carry its code");
	chk_retry_block: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
		start_req && err_pending && is_lock_op(req_op) && (state_r == ST_IDLE)
		|=> state_r == ST_IDLE && refused_r)
		else $error("Lock operation started while errors were pending");
	chk_rp_follow: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
		!pg_sync |=> !o_reset_powerdown_n && !o_reset_powerdown_elevate)
		else $error("Reset pin not low while power is not good");
	chk_ready_first: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
		state_r == ST_CHECK |-> status_byte_r[SB_READY] && $past(state_r) == ST_RD_HOLD)
		else $error("Status check ran before the device was ready");
	chk_sticky_keep: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
		state_r == ST_CHECK |=> state_r == ST_IDLE && (err_r & $past(err_r)) == $past(err_r))
		else $error("Status check lost an accumulated error");

endmodule

// >>> verif/flash_dev_model.sv
// Purpose: Behavioural byte-wide flash that answers lock-bit commands and status reads.
// Assumes: A command latches when the first of chip select and write strobe rises.
// Notes: The bench sets the busy time and the fault inputs that pick each outcome.
`timescale 1ns/1ps
module flash_dev_model (
	input wire logic i_ref_clk,
	input wire logic [19:0] i_addr,
	input wire logic [7:0] i_dq,
	input wire logic i_ce_n,
	input wire logic i_oe_n,
	input wire logic i_we_n,
	input wire logic i_rp_n,
	input wire logic i_rp_elev,
	input wire logic i_master_locked,
	input wire logic i_supply_bad,
	input wire logic i_seq_bad,
	input wire logic [8:0] i_busy_cyc,
	output logic [7:0] o_dq,
	output logic o_dq_oe,
	output logic o_ready_busy
);
	logic [7:0] cmd_r = 8'h00, prev_r = 8'h00, sr_r = 8'h00;
	logic [19:0] addr_r = 20'h00000;
	logic [8:0] busy_r = 9'h000;
	logic stat_mode_r = 1'b0, go_r = 1'b0, seen_r = 1'b0;
	int n_cmd = 0;
	logic wsel;

	// The write is active only while both strobes are low; its end latches the byte.
	assign wsel = !i_ce_n && !i_we_n;

	// =========================================================
	// Outcome of a confirm byte that follows the setup byte.
	function automatic logic [7:0] outcome(input logic [7:0] c);
		logic p;
		logic f;
		p = (c == 8'hF1) ? !i_rp_elev : (i_master_locked && !i_rp_elev);
		f = p || i_supply_bad;
		if (i_seq_bad || (c != 8'h01 && c != 8'hF1 && c != 8'hD0))
			return 8'h30;
		return {2'b00, c == 8'hD0 && f, c != 8'hD0 && f, i_supply_bad, 1'b0, p, 1'b0};
	endfunction

	// =========================================================
	// Command decoder; error bits only ever gather until the clear command or a low reset pin.
	always @(negedge wsel or negedge i_rp_n)
	begin
		if (!i_rp_n)
		begin
			stat_mode_r <= 1'b0;
			sr_r <= 8'h00;
			cmd_r <= 8'h00;
		end
		else if (i_rp_n)
		begin
			prev_r <= cmd_r;
			cmd_r <= i_dq;
			addr_r <= i_addr;
			n_cmd <= n_cmd + 1;
			if (cmd_r == 8'h60)
			begin
				stat_mode_r <= 1'b1;
				go_r <= !go_r;
				sr_r <= sr_r | outcome(i_dq);
			end
			else if (i_dq == 8'hFF)
				stat_mode_r <= 1'b0;
			else if (i_dq == 8'h50)
				sr_r <= 8'h00;
			else if (i_dq == 8'h60)
				stat_mode_r <= 1'b1;
		end
	end

	// Busy countdown of the internal algorithm.
	always @(posedge i_ref_clk)
	begin
		if (go_r != seen_r)
		begin
			seen_r <= go_r;
			busy_r <= i_busy_cyc;
		end
		else if (busy_r != 9'h000)
			busy_r <= busy_r - 9'h001;
	end

	// Ready pin, and data driven only while selected and read-enabled.
	assign o_ready_busy = (busy_r == 9'h000) || !i_rp_n;
	assign o_dq_oe = !i_ce_n && !i_oe_n && i_rp_n;
	assign o_dq = !stat_mode_r ? (i_addr[7:0] ^ 8'hA5) :
		(busy_r != 9'h000) ? 8'h55 : {1'b1, sr_r[6:0]};
endmodule

// >>> verif/flash_lock_host_tb.sv
// Purpose: Self-checking bench for the lock-bit host controller.
// Assumes: The controller faces the behavioural flash model; APB answers with no waits.
// Notes: Master lock, supply fault and busy times are drawn at random from a fixed seed; the sequence fault is forced in one pass only.
`timescale 1ns/1ps
module flash_lock_host_tb;
	import flash_host_pkg::*;
	logic clk, rstn, psel, penable, pwrite, pready, pslverr, err, el, ml, sb;
	logic dq_oe, ce_n, oe_n, we_n, rp_n, rp_el, m_oe, ryby, mlock, supbad, sq, pg;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [19:0] faddr, a;
	logic [7:0] dq_out, m_dq, dq_last, dq_wire;
	logic [8:0] bcyc;
	logic [4:0] e;
	logic [2:0] op;
	int mismatches, comparisons, n;

	flash_lock_host dut (.i_ref_clk(clk), .i_rstn(rstn), .i_psel(psel),
		.i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
		.o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .o_flash_addr(faddr),
		.o_flash_dq_out(dq_out), .o_flash_dq_oe(dq_oe), .i_flash_dq_in(dq_wire),
		.o_flash_ce_n(ce_n), .o_flash_oe_n(oe_n), .o_flash_we_n(we_n),
		.o_reset_powerdown_n(rp_n), .o_reset_powerdown_elevate(rp_el),
		.i_ready_busy_output(ryby), .i_system_power_good(pg));
	flash_dev_model dev (.i_ref_clk(clk), .i_addr(faddr), .i_dq(dq_out), .i_ce_n(ce_n),
		.i_oe_n(oe_n), .i_we_n(we_n), .i_rp_n(rp_n), .i_rp_elev(rp_el),
		.i_master_locked(mlock), .i_supply_bad(supbad), .i_seq_bad(sq), .i_busy_cyc(bcyc),
		.o_dq(m_dq),
		.o_dq_oe(m_oe), .o_ready_busy(ryby));

	// =========================================================
	// Data wire: a released bus shows a pattern that flips every cycle.
	assign dq_wire = dq_oe ? dq_out : (m_oe ? m_dq : ~dq_last);
	always @(posedge clk)
		dq_last <= rstn ? dq_wire : 8'h00;

	// Clock of 200 MHz.
	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// Prints the verdict and ends the run.
	task automatic conclude();
		if (mismatches == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// Compares one value and reports a difference at once.
	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		comparisons++;
		if (got !== exp)
		begin
			mismatches++;
			$display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask

	// One APB transfer; read data and error are taken at the pready edge.
	task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
		int k;
		k = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do
		begin
			@(posedge clk);
			k++;
		end
		while (pready !== 1'b1 && k < 100);
		if (k >= 100)
			mismatches++;
		if (k >= 100)
			conclude();
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask

	// Starts an operation and polls the busy flag; q ends as the status word.
	task automatic run(input logic [2:0] o, input logic ev);
		int k;
		k = 0;
		apb(1'b1, REG_CTRL, {26'h0, 1'b0, ev, 1'b0, o});
		do
		begin
			apb(1'b0, REG_STATUS, 32'h0);
			k++;
		end
		while (q[STAT_BUSY_BIT] !== 1'b0 && k < 400);
		if (k >= 400)
			mismatches++;
		if (k >= 400)
			conclude();
	endtask

	// Expected sticky errors: {set, clear, sequence, protect, supply}.
	function automatic logic [4:0] exp_err(input logic [2:0] o, input logic m, input logic v,
		input logic s, input logic c);
		logic p;
		p = (o == OP_SET_MASTER) ? !v : (m && !v);
		if (c)
			return 5'h04;
		return {o != OP_CLEAR_LOCKS && (p || s), o == OP_CLEAR_LOCKS && (p || s), 1'b0, p, s};
	endfunction

	// Expected status byte for a ready device with the given errors.
	function automatic logic [7:0] sbyte(input logic [4:0] x);
		return {2'b10, x[3] | x[2], x[4] | x[2], x[0], 1'b0, x[1], 1'b0};
	endfunction

	// Expected confirm byte of a lock operation.
	function automatic logic [7:0] conf(input logic [2:0] o);
		return (o == OP_SET_BLOCK) ? CODE_BLOCK_CONFIRM :
			(o == OP_SET_MASTER) ? CODE_MASTER_CONFIRM : CODE_CLEAR_CONFIRM;
	endfunction

	// Run limit.
	initial
	begin
		repeat (100000) @(posedge clk);
		mismatches++;
		conclude();
	end

	// Main sequence.
	initial
	begin
		{rstn, psel, penable, pwrite, mlock, supbad, sq} = '0;
		pg = 1'b1;
		{paddr, pwdata, bcyc} = '0;
		mismatches = 0;
		comparisons = 0;
		void'($urandom(31));
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		repeat (4) @(posedge clk);
		apb(1'b0, REG_STATUS, 32'h0);
		check(q[12:0], 13'h0002, "status after reset");
		apb(1'b0, 12'h010, 32'h0);
		check({31'h0, err}, 32'h1, "unmapped error");
		for (int i = 0; i < 14; i++)
		begin
			op = (i < 3) ? 3'(i + 1) : 3'(1 + $urandom_range(2));
			el = (i < 3) ? 1'b0 : 1'($urandom_range(1));
			ml = (i == 2) ? 1'b1 : 1'($urandom_range(1));
			sb = (i > 2) && ($urandom_range(3) == 0);
			a = 20'($urandom);
			mlock <= ml;
			supbad <= sb;
			sq <= (i == 3);
			bcyc <= 9'($urandom_range(300, 1));
			apb(1'b1, REG_ADDR, {12'h0, a});
			run(op, el);
			e = exp_err(op, ml, el, sb, i == 3);
			check(q[12:8], e, "sticky errors");
			check(q[23:16], sbyte(e), "status byte");
			check({dev.prev_r, dev.cmd_r}, {CODE_LOCK_SETUP, conf(op)}, "lock pair");
			if (op != OP_CLEAR_LOCKS)
				check(dev.addr_r, a, "lock address");
			apb(1'b0, REG_CTRL, 32'h0);
			check(q[5:0], {1'b0, el, 1'b0, op}, "ctrl readback");
			if (e != 5'h00)
			begin
				n = dev.n_cmd;
				run(OP_SET_BLOCK, el);
				check(q[STAT_REFUSED_BIT], 1'b1, "retry refused");
				check(dev.n_cmd, n, "no write on refusal");
				run(OP_READ_STATUS, 1'b0);
				apb(1'b0, REG_DATA, 32'h0);
				check(q[7:0], sbyte(e), "errors still held");
				run(OP_CLEAR_STATUS, 1'b0);
				check(q[12:8], 5'h00, "errors cleared");
				check(dev.cmd_r, CODE_CLEAR_STATUS_DEF, "clear code");
			end
		end
		run(OP_READ_ARRAY, 1'b0);
		check(dev.cmd_r, CODE_READ_ARRAY, "read array code");
		run(OP_READ_STATUS, 1'b0);
		apb(1'b0, REG_DATA, 32'h0);
		check(q[7:0], a[7:0] ^ 8'hA5, "array byte");
		apb(1'b1, REG_CTRL, 32'h20);
		repeat (4) @(posedge clk);
		apb(1'b0, REG_STATUS, 32'h0);
		check({rp_n, q[STAT_RYBY_BIT]}, 2'b01, "powerdown pin");
		apb(1'b1, REG_CTRL, 32'h0);
		pg <= 1'b0;
		repeat (4) @(posedge clk);
		check(rp_n, 1'b0, "pin low without power good");
		pg <= 1'b1;
		conclude();
	end
endmodule
